// ==== hdl/bst_serial_top.sv ====
// Buffered serial port: transmit framing, receive chain and APB registers.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bst_defines.svh"
module bst_serial_top (
  input  wire logic                  pclk,    // System clock, 10 MHz.
  input  wire logic                  presetn, // Asynchronous reset.
  input  wire bst_pkg::bst_apb_req_s apb_req, // APB request.
  output var  bst_pkg::bst_apb_rsp_s apb_rsp, // APB response.
  input  wire bst_pkg::bst_ser_in_s  ser_in,  // Serial pins in.
  output var  bst_pkg::bst_ser_out_s ser_out  // Serial data out.
);
  import bst_pkg::*;

  bst_state_s  s_q;
  bst_state_s  s_d;
  bst_ser_in_s pin_s;
  logic        rise;
  logic        fall;
  logic        fs_ev;
  logic        setup;
  logic        acc;
  logic        adv;
  logic        mapped;
  logic [31:0] rd_val;
  logic [7:0]  cmp_code;
  logic        tx_phase_count_select;
  logic        tx_frame_sync_ignore;
  logic [1:0]  tx_companding_select;
  logic [1:0]  tx_first_bit_delay;
  logic [6:0]  tx_phase1_frame_words;
  logic [6:0]  tx_phase2_frame_words;
  logic [2:0]  tx_phase1_word_size;
  logic [2:0]  tx_phase2_word_size;
  logic [6:0]  cur_fl;
  logic [2:0]  cur_wl;
  logic [4:0]  cur_last;

  // ----------------------------------------------------------------
  // Pin sampling and compression
  // ----------------------------------------------------------------
  bst_sync #(.W(3)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ser_in),
    .q     (pin_s)
  );

  bst_compander u_cmp (
    .lin  (s_q.tx_data_reg[15:0]),
    .alaw (tx_companding_select[0]),
    .code (cmp_code)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign tx_phase_count_select =
    s_q.transmit_control_two[`BST_PHASE_BIT];
  assign tx_frame_sync_ignore  = s_q.transmit_control_two[`BST_FIG_BIT];
  assign tx_companding_select  =
    s_q.transmit_control_two[`BST_CMP_MSB:`BST_CMP_LSB];
  assign tx_first_bit_delay    =
    s_q.transmit_control_two[`BST_DLY_MSB:`BST_DLY_LSB];
  assign tx_phase1_frame_words =
    s_q.transmit_control_one[`BST_FLEN_MSB:`BST_FLEN_LSB];
  assign tx_phase2_frame_words =
    s_q.transmit_control_two[`BST_FLEN_MSB:`BST_FLEN_LSB];
  assign tx_phase1_word_size   =
    s_q.transmit_control_one[`BST_WLEN_MSB:`BST_WLEN_LSB];
  assign tx_phase2_word_size   =
    s_q.transmit_control_two[`BST_WLEN_MSB:`BST_WLEN_LSB];
  assign cur_fl   = s_q.phase ? tx_phase2_frame_words
                              : tx_phase1_frame_words;
  // Decoded in place: a function called here would only follow its
  // argument, so a new word size would never reach the bit counter.
  assign cur_wl   = s_q.phase ? tx_phase2_word_size
                              : tx_phase1_word_size;
  assign cur_last = last_of(cur_wl);

  // Bit clock is sampled by pclk; edges are found on the synced copy.
  assign rise  = pin_s.bit_clock & ~s_q.sclk_p;
  assign fall  = ~pin_s.bit_clock & s_q.sclk_p;
  assign fs_ev = fall & pin_s.frame_sync;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc   = apb_req.psel & apb_req.penable & s_q.pready;

  function automatic logic [2:0] wl_of(input logic ph);
    wl_of = ph ? tx_phase2_word_size : tx_phase1_word_size;
  endfunction : wl_of

  // Reserved size codes fall back to the widest word.
  function automatic logic [4:0] last_of(input logic [2:0] wl);
    last_of = (wl <= `BST_WLEN_TOP)
            ? 5'(`BST_LAST_MIN + `BST_LAST_STEP * wl)
            : `BST_LAST_MAX;
  endfunction : last_of

  function automatic logic [4:0] idx_of(input logic [4:0] b,
                                        input logic [2:0] wl);
    if (tx_companding_select == `BST_CMP_LSB_FIRST &&
        wl == `BST_WLEN_8) begin
      idx_of = b;
    end else begin
      idx_of = 5'(last_of(wl) - b);
    end
  endfunction : idx_of

  function automatic logic [31:0] load_of(input logic [2:0] wl);
    if (wl == `BST_WLEN_8 && tx_companding_select[1]) begin
      load_of = {24'h000000, cmp_code};
    end else begin
      load_of = s_q.tx_data_reg;
    end
  endfunction : load_of

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    case (apb_req.paddr)
      `BST_ADDR_CTL_ONE: rd_val = {16'h0000, s_q.transmit_control_one};
      `BST_ADDR_CTL_TWO: rd_val = {16'h0000, s_q.transmit_control_two};
      `BST_ADDR_TX_DATA: rd_val = s_q.tx_data_reg;
      `BST_ADDR_RX_DATA: rd_val = s_q.rx_data_reg;
      `BST_ADDR_ENABLE:  rd_val = {30'h00000000, s_q.en};
      `BST_ADDR_STATUS:  rd_val = {26'h0000000, s_q.st != BST_IDLE,
                                   s_q.ovr, s_q.rxbuf_full, s_q.rxd_full,
                                   ~s_q.sh_full, ~s_q.txd_full};
      default: begin
        rd_val = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    adv        = 1'b0;
    s_d.sclk_p = pin_s.bit_clock;
    s_d.pready = 1'b0;

    // Transmit sequencer; fs and rise never share a cycle.
    if (!s_q.en[`BST_EN_TX_BIT]) begin
      s_d.st      = BST_IDLE;
      s_d.phase   = 1'b0;
      s_d.sh_full = 1'b0;
    end else if (fs_ev && (s_q.st == BST_IDLE ||
                           !tx_frame_sync_ignore)) begin
      s_d.st    = BST_DELAY;
      s_d.phase = 1'b0;
      s_d.wcnt  = 7'h00;
      s_d.bcnt  = 5'h00;
      s_d.dcnt  = (tx_first_bit_delay == `BST_DLY_RSVD)
                ? `BST_DLY_MAX : tx_first_bit_delay;
    end else if (rise) begin
      unique case (s_q.st)
        BST_IDLE: ;
        BST_DELAY: begin
          if (s_q.dcnt == 2'h0) begin
            s_d.st = BST_SHIFT;
            adv    = 1'b1;
          end else begin
            s_d.dcnt = s_q.dcnt - 2'h1;
          end
        end
        BST_SHIFT: begin
          adv = 1'b1;
          if (s_q.bcnt != cur_last) begin
            s_d.bcnt = s_q.bcnt + 5'h01;
          end else begin
            // The last bit has left, so the shift register is free.
            s_d.bcnt    = 5'h00;
            s_d.sh_full = 1'b0;
            if (s_q.wcnt != cur_fl) begin
              s_d.wcnt = s_q.wcnt + 7'h01;
            end else if (!s_q.phase && tx_phase_count_select) begin
              s_d.phase = 1'b1;
              s_d.wcnt  = 7'h00;
            end else begin
              s_d.st    = BST_IDLE;
              s_d.phase = 1'b0;
              adv       = 1'b0;
            end
          end
        end
        default: s_d.st = BST_IDLE;
      endcase
    end

    // Second transmit stage fills the moment the shift register frees.
    if (s_q.en[`BST_EN_TX_BIT] && !s_d.sh_full && s_q.txd_full) begin
      s_d.tx_shift_reg = load_of(wl_of(s_d.phase));
      s_d.sh_full      = 1'b1;
      s_d.txd_full     = 1'b0;
    end
    if (adv) begin
      s_d.dout = s_d.tx_shift_reg[idx_of(s_d.bcnt, wl_of(s_d.phase))];
    end

    // APB slave: zero wait states, answer registered in setup.
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.slverr = ~mapped;
      s_d.prdata = rd_val;
      s_d.rd_pop = ~apb_req.pwrite & s_q.rxd_full &
                   (apb_req.paddr == `BST_ADDR_RX_DATA);
    end
    if (acc && apb_req.pwrite) begin
      case (apb_req.paddr)
        `BST_ADDR_CTL_ONE: s_d.transmit_control_one =
          apb_req.pwdata[15:0] & `BST_CTL_ONE_WMASK;
        `BST_ADDR_CTL_TWO: s_d.transmit_control_two = apb_req.pwdata[15:0];
        `BST_ADDR_TX_DATA: begin
          s_d.tx_data_reg = apb_req.pwdata;
          s_d.txd_full    = 1'b1;
        end
        `BST_ADDR_ENABLE: s_d.en = apb_req.pwdata[1:0];
        `BST_ADDR_STATUS: begin
          if (apb_req.pwdata[`BST_ST_OVR_BIT]) begin
            s_d.ovr = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Only the word that the read returned is consumed.
    if (acc && s_q.rd_pop) begin
      s_d.rxd_full = 1'b0;
      s_d.rd_pop   = 1'b0;
    end

    // Receive chain: shift register, buffer stage, data register.
    if (!s_d.rxd_full && s_q.rxbuf_full) begin
      s_d.rx_data_reg = s_q.rx_buffer_stage;
      s_d.rxd_full    = 1'b1;
      s_d.rxbuf_full  = 1'b0;
    end
    // Receive shares the transmit frame timing, sampling on falling edges.
    if (s_q.en[`BST_EN_RX_BIT] && fall && s_q.st == BST_SHIFT) begin
      s_d.rx_shift_reg[idx_of(s_q.bcnt, cur_wl)] = pin_s.serial_data_in_pin;
      if (s_q.bcnt == cur_last) begin
        if (!s_d.rxbuf_full) begin
          s_d.rx_buffer_stage = s_d.rx_shift_reg;
          s_d.rxbuf_full      = 1'b1;
        end else begin
          s_d.ovr = 1'b1;
        end
        s_d.rx_shift_reg = 32'h00000000;
      end
    end
    s_d.oe = s_d.en[`BST_EN_TX_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                      <= '0;
      s_q.transmit_control_one <= `BST_CTL_RESET;
      s_q.transmit_control_two <= `BST_CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = '{prdata: s_q.prdata, pready: s_q.pready,
                     pslverr: s_q.slverr};
  assign ser_out = '{serial_data_out_pin: s_q.dout,
                     serial_data_out_oe: s_q.oe};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  out_float_a: assert property (
    !s_q.en[`BST_EN_TX_BIT] |-> !ser_out.serial_data_out_oe)
    else $error("data output driven while transmitter in reset");
  wait_sync_a: assert property (
    s_q.st == BST_IDLE && !fs_ev |=> s_q.st == BST_IDLE)
    else $error("transmit left idle without frame sync");
  start_delay_a: assert property (
    s_q.en[`BST_EN_TX_BIT] && fs_ev && s_q.st == BST_IDLE
    |=> s_q.st == BST_DELAY && s_q.dcnt ==
        ($past(tx_first_bit_delay) == `BST_DLY_RSVD
         ? `BST_DLY_MAX : $past(tx_first_bit_delay)))
    else $error("wrong first bit delay");
  sync_ignore_a: assert property (
    s_q.st == BST_SHIFT && fs_ev && tx_frame_sync_ignore
    |=> s_q.st == BST_SHIFT && $stable(s_q.wcnt) && $stable(s_q.phase))
    else $error("ignored frame sync disturbed frame");
  sync_restart_a: assert property (
    s_q.en[`BST_EN_TX_BIT] && s_q.st == BST_SHIFT && fs_ev &&
    !tx_frame_sync_ignore |=> s_q.st == BST_DELAY && s_q.wcnt == 7'h00)
    else $error("frame sync did not restart transfer");
  bit_range_a: assert property (
    s_q.st == BST_SHIFT |-> s_q.bcnt <= cur_last)
    else $error("bit count beyond word size");
  word_range_a: assert property (
    s_q.st != BST_IDLE |-> s_q.wcnt <= cur_fl)
    else $error("word count beyond frame length");
  one_phase_a: assert property (
    !tx_phase_count_select && $stable(tx_phase_count_select) &&
    s_q.st != BST_IDLE |-> !s_q.phase)
    else $error("second phase in single-phase frame");
  load_empty_a: assert property (
    s_q.en[`BST_EN_TX_BIT] && !s_q.sh_full && s_q.txd_full
    |=> s_q.sh_full)
    else $error("empty shift register not loaded");
  compand_load_a: assert property (
    s_q.en[`BST_EN_TX_BIT] && !s_q.sh_full && s_q.txd_full &&
    s_q.st == BST_IDLE && cur_wl == `BST_WLEN_8 &&
    tx_companding_select[1]
    |=> s_q.tx_shift_reg == {24'h000000, $past(cmp_code)})
    else $error("companded word not loaded");
  msb_first_a: assert property (
    s_q.st == BST_DELAY && rise && s_q.dcnt == 2'h0 && s_q.sh_full &&
    tx_companding_select == `BST_CMP_PLAIN
    |=> ser_out.serial_data_out_pin == s_q.tx_shift_reg[cur_last])
    else $error("first bit not most significant");
  rx_hold_a: assert property (
    s_q.rxd_full && !(acc && s_q.rd_pop)
    |=> s_q.rxd_full && $stable(s_q.rx_data_reg))
    else $error("unread receive data overwritten");
  rxbuf_hold_a: assert property (
    s_q.rxbuf_full && s_q.rxd_full && !acc |=> $stable(s_q.rx_buffer_stage))
    else $error("full buffer stage overwritten");

  dual_done_c: cover property (
    s_q.phase && s_q.st == BST_SHIFT ##1 s_q.st == BST_IDLE);
  overrun_c: cover property ($rose(s_q.ovr));
  restart_c: cover property (s_q.st == BST_SHIFT && fs_ev &&
                             !tx_frame_sync_ignore);
endmodule : bst_serial_top
`default_nettype wire

// ==== hdl/bst_defines.svh ====
// Register map, field positions and fixed codes of the serial transmit block.
// Summary of operation
// - Phase bit 15 of control two: 0 single-phase, 1 dual-phase frame.
// - Frame length field bits 14-8 gives words per phase as value plus one.
// - Word size field bits 7-5: 8,12,16,20,24,32 bits; 11X reserved.
// - Companding bits 4-3 act only when the word size code is 000.
// - Companding code 00 sends plain data, most significant bit first.
// - Companding code 01 sends plain eight-bit data, LSB first.
// - Code 10 compresses with mu-law, code 11 compresses with A-law.
// - With ignore bit 2 clear, a later frame sync restarts the transfer.
// - With ignore bit set, later frame syncs are ignored; frame goes on.
// - Delay bits 1-0 put the first bit 0, 1 or 2 bit clocks late.
// - Receive path holds three buffer stages, transmit path holds two.
// - A complete received word enters the buffer stage only if empty.
// - Buffer stage moves to receive data register after the last read.
// - Empty shift register loads at once; a busy one after its last bit.
// - Shifting onto the data output starts only after a frame sync.
// - The data output floats while the transmitter or device is in reset.
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

`define BST_ADDR_CTL_ONE  12'h000
`define BST_ADDR_CTL_TWO  12'h004
`define BST_ADDR_TX_DATA  12'h008
`define BST_ADDR_RX_DATA  12'h00C
`define BST_ADDR_ENABLE   12'h010
`define BST_ADDR_STATUS   12'h014

`define BST_CTL_RESET     16'h0000
`define BST_CTL_ONE_WMASK 16'h7FE0
`define BST_PHASE_BIT     15
`define BST_FLEN_MSB      14
`define BST_FLEN_LSB      8
`define BST_WLEN_MSB      7
`define BST_WLEN_LSB      5
`define BST_CMP_MSB       4
`define BST_CMP_LSB       3
`define BST_FIG_BIT       2
`define BST_DLY_MSB       1
`define BST_DLY_LSB       0
`define BST_EN_TX_BIT     0
`define BST_EN_RX_BIT     1
`define BST_ST_OVR_BIT    4

`define BST_CMP_PLAIN     2'b00
`define BST_CMP_LSB_FIRST 2'b01
`define BST_DLY_RSVD      2'b11
`define BST_DLY_MAX       2'b10
`define BST_WLEN_8        3'h0
`define BST_WLEN_TOP      3'h4
`define BST_LAST_MIN      5'h07
`define BST_LAST_STEP     5'h04
`define BST_LAST_MAX      5'h1F

`define BST_MULAW_BIAS    16'h0084
`define BST_LIN_CLIP      16'h7F7B
`define BST_ALAW_XOR      8'h55

`endif

// ==== hdl/bst_pkg.sv ====
// Types shared by the buffered serial transmit block.
package bst_pkg;

  typedef enum logic [1:0] {
    BST_IDLE  = 2'b00,
    BST_DELAY = 2'b01,
    BST_SHIFT = 2'b11
  } bst_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bst_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bst_apb_rsp_s;

  typedef struct packed {
    logic bit_clock;
    logic frame_sync;
    logic serial_data_in_pin;
  } bst_ser_in_s;

  typedef struct packed {
    logic serial_data_out_pin;
    logic serial_data_out_oe;
  } bst_ser_out_s;

  typedef struct packed {
    logic [15:0] transmit_control_one;
    logic [15:0] transmit_control_two;
    logic [1:0]  en;
    logic [31:0] tx_data_reg;
    logic        txd_full;
    logic [31:0] tx_shift_reg;
    logic        sh_full;
    bst_state_e  st;
    logic [1:0]  dcnt;
    logic        phase;
    logic [6:0]  wcnt;
    logic [4:0]  bcnt;
    logic        dout;
    logic        oe;
    logic        sclk_p;
    logic [31:0] rx_shift_reg;
    logic [31:0] rx_buffer_stage;
    logic        rxbuf_full;
    logic [31:0] rx_data_reg;
    logic        rxd_full;
    logic        ovr;
    logic        rd_pop;
    logic [31:0] prdata;
    logic        pready;
    logic        slverr;
  } bst_state_s;

endpackage : bst_pkg

// ==== hdl/bst_sync.sv ====
// Two-flop synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module bst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Sampling clock.
  input  wire logic         rst_n, // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,     // Asynchronous inputs.
  output var  logic [W-1:0] q      // Synchronised outputs.
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : bst_sync
`default_nettype wire

// ==== hdl/bst_compander.sv ====
// Linear to eight-bit mu-law or A-law compressor.
`timescale 1ns/10ps
`default_nettype none
`include "bst_defines.svh"
module bst_compander (
  input  wire logic [15:0] lin,  // Signed linear sample.
  input  wire logic        alaw, // High selects A-law, low mu-law.
  output logic      [7:0]  code  // Compressed byte.
);
  logic        sgn;
  logic [15:0] mag;
  logic [15:0] bm;
  logic [2:0]  ex;
  logic [3:0]  mt;

  always_comb begin
    sgn = lin[15];
    mag = sgn ? 16'(~lin + 16'h0001) : lin;
    if (mag > `BST_LIN_CLIP) begin
      mag = `BST_LIN_CLIP;
    end
    bm = alaw ? mag : 16'(mag + `BST_MULAW_BIAS);
    ex = 3'h0;
    for (int i = 8; i < 15; i++) begin
      if (bm[i]) begin
        ex = 3'(i - 7);
      end
    end
    // A-law keeps a linear segment below the first chord.
    if (alaw && ex == 3'h0) begin
      mt = bm[7:4];
    end else begin
      mt = 4'(bm >> (ex + 3'h3));
    end
    code = alaw ? ({~sgn, ex, mt} ^ `BST_ALAW_XOR) : ~{sgn, ex, mt};
  end
endmodule : bst_compander
`default_nettype wire

// ==== tb/bst_peer_model.sv ====
// Serial peer model: bit clock, frame sync, receive data and capture.
`timescale 1ns/10ps
`default_nettype none
module bst_peer_model (
  output var  logic bit_clock,  // Bit clock, still outside frames.
  output var  logic frame_sync, // Frame sync, active high.
  output var  logic data_in,    // Data towards the receiver.
  input  wire logic data_out,   // Transmit data pin.
  input  wire logic data_oe     // Transmit pin drive enable.
);
  initial begin
    bit_clock  = 1'b0;
    frame_sync = 1'b0;
    data_in    = 1'b0;
  end
  // ---------------------------------------------------------------
  // One frame of n bits after a delay of d bit clocks
  // ---------------------------------------------------------------
  // The output is sampled just before the next rising edge, because
  // the block drives it a few system clocks after that edge. A pin that
  // is not driven is captured as unknown so it never passes for a bit.
  task automatic frame(input int n, input int d, input int resync,
                       input logic follow, input logic [31:0] rx,
                       output logic [31:0] cap);
    int   s;
    int   k;
    logic inw;
    s   = 0;
    cap = 32'h0;
    #13;
    for (int c = 0; c <= s + d + n; c++) begin
      if (follow && c == resync) begin
        s   = c;
        cap = 32'h0;
      end
      k          = c - s - d - 1;
      inw        = (k >= 0) && (k < n);
      bit_clock  = 1'b1;
      frame_sync = (c == 0) || (c == resync);
      data_in    = inw ? rx[n - 1 - k] : ~data_in;
      #400;
      bit_clock = 1'b0;
      #395;
      frame_sync = 1'b0;
      if (inw) begin
        cap = {cap[30:0], data_oe ? data_out : 1'bx};
      end
      #5;
    end
  endtask : frame
endmodule : bst_peer_model
`default_nettype wire

// ==== tb/buffered_serial_tx_framing_datapath_tb.sv ====
// Self-checking bench of the buffered serial transmit block.
`timescale 1ns/10ps
`default_nettype none
`include "bst_defines.svh"
module buffered_serial_tx_framing_datapath_tb;
  import bst_pkg::*;
  bst_apb_req_s req;
  bst_apb_rsp_s rsp;
  bst_ser_in_s  sin;
  bst_ser_out_s sout;
  logic         pclk;
  logic         presetn;
  logic         serr;
  logic [31:0]  rdat;
  logic [31:0]  cap;
  logic [31:0]  w1;
  logic [31:0]  w2;
  int           num_errors;
  int           compares;
  int           seed;

  always #50 pclk = ~pclk;

  bst_serial_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .ser_in(sin), .ser_out(sout));
  bst_peer_model i_peer (.bit_clock(sin.bit_clock),
    .frame_sync(sin.frame_sync), .data_in(sin.serial_data_in_pin),
    .data_out(sout.serial_data_out_pin),
    .data_oe(sout.serial_data_out_oe));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
      if (i == 19) begin
        num_errors++;
        report_and_stop();
      end
    end
    rdat = rsp.prdata;
    serr = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Fields are changed only while both portions are held in reset.
  task automatic setup(input logic [15:0] c1, input logic [15:0] c2,
                       input logic [31:0] d);
    apb(1'b1, `BST_ADDR_ENABLE, 32'h0);
    apb(1'b1, `BST_ADDR_CTL_ONE, {16'h0, c1});
    apb(1'b1, `BST_ADDR_CTL_TWO, {16'h0, c2});
    apb(1'b1, `BST_ADDR_TX_DATA, d);
    apb(1'b1, `BST_ADDR_ENABLE, 32'h3);
  endtask : setup

  function automatic int wbits(input logic [2:0] wl);
    return (wl > 3'h4) ? 32 : 8 + 4 * int'(wl);
  endfunction : wbits

  // Compressed codes are known only for a zero sample, so the
  // mu-law and A-law cases always send zero.
  function automatic logic [31:0] exp_word(input logic [2:0] wl,
      input logic [1:0] cm, input logic [31:0] d);
    logic [31:0] r;
    int          n;
    n = wbits(wl);
    r = (n == 32) ? d : d & ((32'h1 << n) - 32'h1);
    if (wl == 3'h0 && cm == 2'h2) r = 32'hFF;
    if (wl == 3'h0 && cm == 2'h3) r = 32'hD5;
    if (wl == 3'h0 && cm == 2'h1) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    return r;
  endfunction : exp_word

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [2:0] wl;
    logic [1:0] cm;
    pclk       = 1'b0;
    presetn    = 1'b0;
    req        = '0;
    num_errors = 0;
    compares   = 0;
    seed       = 86;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("oe reset", 32'h0, {31'h0, sout.serial_data_out_oe});
    apb(1'b0, `BST_ADDR_CTL_ONE, 32'h0);
    chk("ctl1 reset", 32'h0, rdat);
    apb(1'b0, `BST_ADDR_CTL_TWO, 32'h0);
    chk("ctl2 reset", 32'h0, rdat);
    apb(1'b1, `BST_ADDR_CTL_ONE, 32'hFFFF);
    apb(1'b0, `BST_ADDR_CTL_ONE, 32'h0);
    chk("ctl1 fields", 32'h7FE0, rdat);
    apb(1'b1, 12'h020, 32'h1);
    chk("unmapped err", 32'h1, {31'h0, serr});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped data", 32'h0, rdat);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      wl = 3'(i);
      w1 = $random(seed);
      setup({8'h0, wl, 5'h0}, {14'h0, 2'(i % 4)}, w1);
      // Reserved delay code 11 acts as the longest delay.
      i_peer.frame(wbits(wl), (i % 4 == 3) ? 2 : i % 4, 0, 1'b0, 32'h0, cap);
      chk("frame", exp_word(wl, 2'h0, w1), cap);
      chk("oe run", 32'h1, {31'h0, sout.serial_data_out_oe});
    end
    $display("test sizes and delays done");
    for (int i = 0; i < 4; i++) begin
      wl = (i == 3) ? 3'h1 : 3'h0;
      cm = (i == 3) ? 2'h1 : 2'(i + 1);
      w1 = (cm == 2'h1) ? $random(seed) : 32'h0;
      setup({8'h0, wl, 5'h0}, {11'h0, cm, 3'h0}, w1);
      i_peer.frame(wbits(wl), 0, 0, 1'b0, 32'h0, cap);
      chk("compand", exp_word(wl, cm, w1), cap);
    end
    $display("test companding done");
    for (int i = 0; i < 2; i++) begin
      w1 = $random(seed);
      w2 = $random(seed);
      setup((i == 0) ? 16'h0100 : 16'h0000,
            (i == 0) ? 16'h0000 : 16'h8040, w1);
      apb(1'b1, `BST_ADDR_TX_DATA, w2);
      apb(1'b0, `BST_ADDR_STATUS, 32'h0);
      chk("tx status", 32'h0, rdat & 32'h3);
      i_peer.frame(16 + 8 * i, 0, 0, 1'b0, 32'h0, cap);
      chk("words", (i == 0) ? {16'h0, w1[7:0], w2[7:0]} :
          {8'h0, w1[7:0], w2[15:0]}, cap);
    end
    $display("test phases done");
    for (int i = 0; i < 2; i++) begin
      w1 = $random(seed);
      setup(16'h0000, {13'h0, 1'(i), 2'h0}, w1);
      i_peer.frame(8, 0, 4, (i == 0), 32'h0, cap);
      chk("resync", {24'h0, w1[7:0]}, cap);
    end
    $display("test frame sync done");
    setup(16'h0000, 16'h0000, 32'h0);
    // Earlier frames left words and an overrun behind; drain them first.
    apb(1'b0, `BST_ADDR_RX_DATA, 32'h0);
    apb(1'b0, `BST_ADDR_RX_DATA, 32'h0);
    apb(1'b1, `BST_ADDR_STATUS, 32'h10);
    apb(1'b0, `BST_ADDR_STATUS, 32'h0);
    chk("rx drained", 32'h0, rdat & 32'h1C);
    for (int i = 0; i < 3; i++) begin
      i_peer.frame(8, 0, 0, 1'b0, 32'hA0 + 32'(i), cap);
    end
    apb(1'b0, `BST_ADDR_STATUS, 32'h0);
    chk("rx status", 32'h1C, rdat & 32'h1C);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, `BST_ADDR_RX_DATA, 32'h0);
      chk("rx data", 32'hA0 + 32'(i), rdat);
    end
    $display("test receive done");
    apb(1'b1, `BST_ADDR_ENABLE, 32'h0);
    repeat (3) @(posedge pclk);
    chk("oe off", 32'h0, {31'h0, sout.serial_data_out_oe});
    $display("test disable done");
    report_and_stop();
  end
endmodule : buffered_serial_tx_framing_datapath_tb
`default_nettype wire
